/* logic/bcp_pkg.sv */
// Shared constants and carrier types for the board cache pin controller
package bcp_pkg;
  // Register map, byte addresses on the APB slave
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_INDEX = 12'h008;
  localparam logic [11:0] OFF_WTAG = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_RTAG = 12'h014;
  // Control fields
  localparam int CTRL_LAG_LSB = 0;
  localparam int CTRL_HALF_LSB = 2;
  localparam int CTRL_EN_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h10;
  // Command bits
  localparam int OP_READ_BIT = 0;
  localparam int OP_WDATA_BIT = 1;
  localparam int OP_WTAG_BIT = 2;
  // Write tag fields
  localparam int WTAG_DIRTY_BIT = 23;
  localparam int WTAG_SHARED_BIT = 24;
  localparam int WTAG_VALID_BIT = 25;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_PARERR_BIT = 2;
  localparam int ST_TMO_BIT = 3;
  localparam int ST_LVALID_BIT = 4;
  localparam int ST_WAKE_BIT = 5;
  localparam int ST_SUPPLY_BIT = 6;
  localparam int ST_NEMPTY_BIT = 7;
  localparam int ST_FULL_BIT = 8;
  localparam int RTAG_ENTRY_BIT = 31;
  // Widths
  localparam int TAG_W = 23;
  localparam int INDEX_W = 20;
  localparam int FWD_PAIRS = 4;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] MAX_LAG = 2'h2;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int TAG_WAIT_NS = 2000;
  localparam int TAG_WAIT_CYC = (TAG_WAIT_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic [TAG_W-1:0] tagAddr;
    logic tagModifiedBit;
    logic tagSharedBit;
    logic tagValidBit;
    logic tagParityBit;
  } bcp_tag_t;

  typedef struct packed {
    logic cacheDataReadEnableN;
    logic cacheDataWriteEnableN;
    logic cacheBurstEnableN;
    logic tagReadEnableN;
    logic tagWriteEnableN;
  } bcp_strobes_t;

  localparam bcp_strobes_t STROBES_IDLE = 5'h1F;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_ACCESS
  } bcp_state_t;
endpackage

/* logic/bcp_cache_pins.sv */
// Board cache pin controller: forwarded clocks, cache strobes, tag path, APB slave
`timescale 1ns/1ps
module bcp_cache_pins
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [bcp_pkg::INDEX_W-1:0] cacheIndexOut,
  output bcp_pkg::bcp_strobes_t cacheStrobes,
  output bcp_pkg::bcp_tag_t cacheTagBusOut,
  output logic cacheTagBusOe,
  input wire bcp_pkg::bcp_tag_t cacheTagBusIn,
  output logic [bcp_pkg::FWD_PAIRS-1:0] cacheDataFwdClockP,
  output logic [bcp_pkg::FWD_PAIRS-1:0] cacheDataFwdClockN,
  output logic tagFwdClockP,
  output logic tagFwdClockN,
  input wire logic tagCaptureClock,
  input wire logic capturedFramingClock,
  input wire logic fwdClockWakeReset,
  input wire logic supplyOkInput,
  output logic wakeRequest
);
  localparam int SYNC_W = $bits(bcp_pkg::bcp_tag_t) + 4;

  function automatic logic [3:0] launch_phase(input logic [3:0] period, input logic [1:0] lag);
    // Pins move one edge after the strobe, so launch one cycle early
    if ({2'h0, lag} >= period)
      launch_phase = period - 4'h1;
    else
      launch_phase = period - 4'h1 - {2'h0, lag};
  endfunction

  function automatic logic tag_parity(input bcp_pkg::bcp_tag_t t);
    tag_parity = ^{t.tagAddr, t.tagModifiedBit, t.tagSharedBit, t.tagValidBit};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic tagClkDly_r;
  logic frameClkDly_r;
  bcp_pkg::bcp_tag_t tagSync;
  logic tagClkSync;
  logic frameClkSync;
  logic wakeSync;
  logic supplyOk;
  logic tagEdge;
  logic frameEdge;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else if (clkEn)
    begin
      sync1_r <= {cacheTagBusIn, tagCaptureClock, capturedFramingClock,
                  fwdClockWakeReset, supplyOkInput};
      sync2_r <= sync1_r;
    end
  end

  assign tagSync = sync2_r[SYNC_W-1:4];
  assign tagClkSync = sync2_r[3];
  assign frameClkSync = sync2_r[2];
  assign wakeSync = sync2_r[1];
  assign supplyOk = sync2_r[0];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tagClkDly_r <= 1'b0;
      frameClkDly_r <= 1'b0;
    end
    else if (clkEn)
    begin
      tagClkDly_r <= tagClkSync;
      frameClkDly_r <= frameClkSync;
    end
  end

  assign tagEdge = tagClkSync & ~tagClkDly_r;
  assign frameEdge = frameClkSync & ~frameClkDly_r;

  // Wake reset is only looked at on framing clock edges
  logic wake_r;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      wake_r <= 1'b0;
    else if (clkEn && frameEdge)
      wake_r <= wakeSync;
  end
  assign wakeRequest = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [4:0] ctrl_r;
  logic [2:0] cmdOp_r;
  logic cmdPend_r;
  logic [bcp_pkg::INDEX_W-1:0] index_r;
  logic [25:0] wtag_r;
  logic parErr_r;
  logic tmo_r;
  logic lineValid_r;
  logic wakeSeen_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic wrAcc;
  logic rdAcc;
  logic setupRd;
  logic errAddr;
  logic cmdTake;
  logic capPush;
  logic capTmo;
  bcp_pkg::bcp_state_t state_r;

  assign wrAcc = psel && penable && pwrite && clkEn;
  assign rdAcc = psel && penable && !pwrite && clkEn;
  assign setupRd = psel && !penable;
  assign errAddr = !(paddr == bcp_pkg::OFF_CTRL || paddr == bcp_pkg::OFF_CMD ||
                     paddr == bcp_pkg::OFF_INDEX || paddr == bcp_pkg::OFF_WTAG ||
                     paddr == bcp_pkg::OFF_STATUS || paddr == bcp_pkg::OFF_RTAG);
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r & penable;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_r <= bcp_pkg::CTRL_RST;
      index_r <= '0;
      wtag_r <= '0;
    end
    else if (wrAcc)
    begin
      if (paddr == bcp_pkg::OFF_CTRL)
        ctrl_r <= pwdata[4:0];
      else if (paddr == bcp_pkg::OFF_INDEX)
        index_r <= pwdata[bcp_pkg::INDEX_W-1:0];
      else if (paddr == bcp_pkg::OFF_WTAG)
        wtag_r <= pwdata[25:0];
    end
  end

  // One command held until the sequencer takes it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cmdOp_r <= '0;
      cmdPend_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrAcc && paddr == bcp_pkg::OFF_CMD && !cmdPend_r && pwdata[2:0] != 3'h0)
      begin
        cmdOp_r <= pwdata[2:0];
        cmdPend_r <= 1'b1;
      end
      else if (cmdTake)
        cmdPend_r <= 1'b0;
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      parErr_r <= 1'b0;
      tmo_r <= 1'b0;
      wakeSeen_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (capPush && tag_parity(tagSync) != tagSync.tagParityBit)
        parErr_r <= 1'b1;
      else if (wrAcc && paddr == bcp_pkg::OFF_STATUS && pwdata[bcp_pkg::ST_PARERR_BIT])
        parErr_r <= 1'b0;
      if (capTmo)
        tmo_r <= 1'b1;
      else if (wrAcc && paddr == bcp_pkg::OFF_STATUS && pwdata[bcp_pkg::ST_TMO_BIT])
        tmo_r <= 1'b0;
      if (wake_r)
        wakeSeen_r <= 1'b1;
      else if (wrAcc && paddr == bcp_pkg::OFF_STATUS && pwdata[bcp_pkg::ST_WAKE_BIT])
        wakeSeen_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      lineValid_r <= 1'b0;
    else if (clkEn && capPush)
      lineValid_r <= tagSync.tagValidBit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer of captured tags, drained by reads of the tag register
  bcp_pkg::bcp_tag_t fifoMem [bcp_pkg::FIFO_DEPTH];
  logic fifoWr_r;
  logic fifoRd_r;
  logic [1:0] fifoCnt_r;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;

  assign fifoInReady = fifoCnt_r != 2'(bcp_pkg::FIFO_DEPTH);
  assign fifoOutValid = fifoCnt_r != 2'h0;
  assign fifoPop = rdAcc && paddr == bcp_pkg::OFF_RTAG && fifoOutValid;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      fifoWr_r <= 1'b0;
      fifoRd_r <= 1'b0;
      fifoCnt_r <= '0;
    end
    else if (clkEn)
    begin
      if (capPush && fifoInReady)
      begin
        fifoMem[fifoWr_r] <= tagSync;
        fifoWr_r <= ~fifoWr_r;
      end
      if (fifoPop)
        fifoRd_r <= ~fifoRd_r;
      fifoCnt_r <= fifoCnt_r + 2'(capPush && fifoInReady) - 2'(fifoPop);
    end
  end

  // Read data registered in the setup phase
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
    else if (clkEn && setupRd)
    begin
      pslverr_r <= errAddr;
      prdata_r <= '0;
      if (paddr == bcp_pkg::OFF_CTRL)
        prdata_r <= {27'h0, ctrl_r};
      else if (paddr == bcp_pkg::OFF_CMD)
        prdata_r <= {28'h0, cmdPend_r, cmdOp_r};
      else if (paddr == bcp_pkg::OFF_INDEX)
        prdata_r <= {12'h0, index_r};
      else if (paddr == bcp_pkg::OFF_WTAG)
        prdata_r <= {6'h0, wtag_r};
      else if (paddr == bcp_pkg::OFF_STATUS)
        prdata_r <= {23'h0, !fifoInReady, fifoOutValid, supplyOk, wakeSeen_r,
                     lineValid_r, tmo_r, parErr_r, cmdPend_r, state_r != bcp_pkg::ST_IDLE};
      else if (paddr == bcp_pkg::OFF_RTAG)
        prdata_r <= {fifoOutValid, 4'h0, fifoMem[fifoRd_r]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarded clock divider; ratio and lag only change at a wrap while idle
  logic [1:0] half_r;
  logic [1:0] lag_r;
  logic [3:0] phase_r;
  logic fwdClk_r;
  logic [3:0] period;
  logic wrapPt;
  logic launchStb;

  assign period = {1'b0, half_r, 1'b0} + 4'h2;
  assign wrapPt = phase_r == period - 4'h1;
  assign launchStb = phase_r == launch_phase(period, lag_r);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      half_r <= '0;
      lag_r <= '0;
      phase_r <= '0;
    end
    else if (clkEn)
    begin
      phase_r <= (wrapPt || wake_r) ? 4'h0 : phase_r + 4'h1;
      if (wrapPt && state_r == bcp_pkg::ST_IDLE)
      begin
        half_r <= ctrl_r[bcp_pkg::CTRL_HALF_LSB +: 2];
        lag_r <= (ctrl_r[1:0] > bcp_pkg::MAX_LAG) ? bcp_pkg::MAX_LAG : ctrl_r[1:0];
      end
    end
  end

  // High for the first half period; rising edge always at phase zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      fwdClk_r <= 1'b0;
    else if (clkEn)
      fwdClk_r <= ctrl_r[bcp_pkg::CTRL_EN_BIT] && (wrapPt || wake_r ||
                  phase_r < {2'h0, half_r});
  end

  assign cacheDataFwdClockP = {bcp_pkg::FWD_PAIRS{fwdClk_r}};
  assign cacheDataFwdClockN = {bcp_pkg::FWD_PAIRS{~fwdClk_r}};
  assign tagFwdClockP = fwdClk_r;
  assign tagFwdClockN = ~fwdClk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer; reads stall while the tag buffer is full
  logic [7:0] waitCnt_r;
  logic isRead;
  logic accessEnd;

  assign isRead = cmdOp_r[bcp_pkg::OP_READ_BIT];
  assign cmdTake = state_r == bcp_pkg::ST_IDLE && cmdPend_r && supplyOk &&
                   (!isRead || fifoInReady) && clkEn;
  assign capPush = state_r == bcp_pkg::ST_ACCESS && isRead && tagEdge;
  assign capTmo = state_r == bcp_pkg::ST_ACCESS && isRead && !tagEdge &&
                  waitCnt_r == 8'(bcp_pkg::TAG_WAIT_CYC);
  assign accessEnd = isRead ? (capPush || capTmo) : launchStb;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_r <= bcp_pkg::ST_IDLE;
      waitCnt_r <= '0;
    end
    else if (clkEn)
    begin
      case (state_r)
        bcp_pkg::ST_IDLE:
          if (cmdTake)
            state_r <= bcp_pkg::ST_ARM;
        bcp_pkg::ST_ARM:
          if (launchStb)
          begin
            state_r <= bcp_pkg::ST_ACCESS;
            waitCnt_r <= '0;
          end
        bcp_pkg::ST_ACCESS:
        begin
          waitCnt_r <= waitCnt_r + 8'h1;
          if (accessEnd)
            state_r <= bcp_pkg::ST_IDLE;
        end
        default:
          state_r <= bcp_pkg::ST_IDLE;
      endcase
    end
  end

  // Pin drivers, all launched on the forwarded clock strobe
  bcp_pkg::bcp_strobes_t strobes_r;
  bcp_pkg::bcp_tag_t tagOut_r;
  logic tagOe_r;
  logic [bcp_pkg::INDEX_W-1:0] indexOut_r;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      strobes_r <= bcp_pkg::STROBES_IDLE;
      tagOut_r <= '0;
      tagOe_r <= 1'b0;
      indexOut_r <= '0;
    end
    else if (clkEn)
    begin
      if (state_r == bcp_pkg::ST_ARM && launchStb)
      begin
        indexOut_r <= index_r;
        strobes_r.cacheBurstEnableN <= 1'b0;
        strobes_r.cacheDataReadEnableN <= !isRead;
        strobes_r.tagReadEnableN <= !isRead;
        strobes_r.cacheDataWriteEnableN <= !cmdOp_r[bcp_pkg::OP_WDATA_BIT];
        strobes_r.tagWriteEnableN <= !cmdOp_r[bcp_pkg::OP_WTAG_BIT];
        tagOe_r <= !isRead && cmdOp_r[bcp_pkg::OP_WTAG_BIT];
        tagOut_r.tagAddr <= wtag_r[bcp_pkg::TAG_W-1:0];
        tagOut_r.tagModifiedBit <= wtag_r[bcp_pkg::WTAG_DIRTY_BIT];
        tagOut_r.tagSharedBit <= wtag_r[bcp_pkg::WTAG_SHARED_BIT];
        tagOut_r.tagValidBit <= wtag_r[bcp_pkg::WTAG_VALID_BIT];
        tagOut_r.tagParityBit <= ^wtag_r;
      end
      else if (state_r == bcp_pkg::ST_ACCESS && accessEnd)
      begin
        strobes_r <= bcp_pkg::STROBES_IDLE;
        tagOe_r <= 1'b0;
      end
    end
  end

  assign cacheStrobes = strobes_r;
  assign cacheTagBusOut = tagOut_r;
  assign cacheTagBusOe = tagOe_r;
  assign cacheIndexOut = indexOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_launch;
    state_r == bcp_pkg::ST_ARM && launchStb && clkEn;
  endsequence

  a_read_data_oe: assert property (@(posedge sys_clk) disable iff (srst)
    s_launch and isRead |=> !cacheStrobes.cacheDataReadEnableN)
    else $error("data read enable missing on read");
  a_tag_oe: assert property (@(posedge sys_clk) disable iff (srst)
    !cacheStrobes.tagReadEnableN |-> !cacheStrobes.cacheDataReadEnableN && !cacheTagBusOe)
    else $error("tag read enable out of place");
  a_write_only: assert property (@(posedge sys_clk) disable iff (srst)
    !cacheStrobes.cacheDataWriteEnableN |-> cacheStrobes.cacheDataReadEnableN)
    else $error("data write enable during read");
  a_fwd_pair: assert property (@(posedge sys_clk) disable iff (srst)
    tagFwdClockP == cacheDataFwdClockP[0] && tagFwdClockN != tagFwdClockP)
    else $error("tag clock differs from data clocks");
  a_clock_lag: assert property (@(posedge sys_clk) disable iff (srst)
    s_launch and (lag_r == 2'h2 && half_r == 2'h1 && ctrl_r[4] && !wake_r)
    |=> ##2 $rose(fwdClk_r))
    else $error("clock edge lag wrong");
  a_tag_launch: assert property (@(posedge sys_clk) disable iff (srst)
    $changed(cacheTagBusOut) |-> $past(launchStb))
    else $error("tag launched off strobe");
  a_dirty_bit: assert property (@(posedge sys_clk) disable iff (srst)
    s_launch and cmdOp_r[2] |=> cacheTagBusOut.tagModifiedBit == $past(wtag_r[23]))
    else $error("modified bit wrong");
  a_shared_bit: assert property (@(posedge sys_clk) disable iff (srst)
    s_launch and cmdOp_r[2] |=> cacheTagBusOut.tagSharedBit == $past(wtag_r[24]))
    else $error("shared bit wrong");
  a_capture_push: assert property (@(posedge sys_clk) disable iff (srst)
    capPush && fifoInReady |=> fifoOutValid && state_r == bcp_pkg::ST_IDLE)
    else $error("captured tag lost");
  a_tag_wr_en: assert property (@(posedge sys_clk) disable iff (srst)
    cacheTagBusOe |-> !cacheStrobes.tagWriteEnableN)
    else $error("tag driven without write enable");
  a_index_hold: assert property (@(posedge sys_clk) disable iff (srst)
    s_launch |=> cacheIndexOut == $past(index_r))
    else $error("index not driven");
  a_wake_frame: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !frameEdge |=> $stable(wake_r))
    else $error("wake sampled off framing edge");
endmodule // bcp_cache_pins

/* testbench/bcp_sram_model.sv */
// Tag SRAM partner model answering reads on the board cache tag bus
`timescale 1ns/1ps
module bcp_sram_model
(
  input wire logic sys_clk,
  input wire logic [bcp_pkg::INDEX_W-1:0] idx,
  input wire bcp_pkg::bcp_strobes_t stb,
  input wire bcp_pkg::bcp_tag_t tagOut,
  input wire logic tagOe,
  input wire logic badParity,
  input wire logic mute,
  output bcp_pkg::bcp_tag_t tagIn,
  output logic capClk
);
  bcp_pkg::bcp_tag_t mem [int];
  bcp_pkg::bcp_tag_t lastVal;
  int cnt;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    lastVal = '0;
    tagIn = '1;
    capClk = 1'b0;
    cnt = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    if (!stb.tagWriteEnableN && tagOe)
      mem[int'(idx)] = tagOut;
    if (stb.tagReadEnableN || mute)
    begin
      // Released bus shows the inverse, so a stale word cannot pass
      cnt = 0;
      capClk <= 1'b0;
      tagIn <= ~lastVal;
    end
    else
    begin
      cnt++;
      if (cnt == 2)
      begin
        lastVal = mem.exists(int'(idx)) ? mem[int'(idx)] : '0;
        lastVal.tagParityBit ^= badParity;
        tagIn <= lastVal;
      end
      // Capture clock only runs inside a read, two cycles after data
      if (cnt == 4)
        capClk <= 1'b1;
    end
  end
endmodule // bcp_sram_model

/* testbench/bcp_cache_pins_bench.sv */
// Self-checking bench for the board cache pin controller
`timescale 1ns/1ps
module bcp_cache_pins_bench;
  logic sys_clk, srst, clkEn, psel, penable, pwrite, pready, pslverr;
  logic tagP, tagN, capClk, frameClk, wakeIn, supplyOk, wakeReq, tagOe;
  logic badPar, mute, prevP, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [bcp_pkg::INDEX_W-1:0] idxOut;
  logic [bcp_pkg::FWD_PAIRS-1:0] dP, dN;
  bcp_pkg::bcp_strobes_t stb;
  bcp_pkg::bcp_tag_t tagOut, tagIn;
  int errCount, nChecks;
  ////////////////////////////////////////////////////////////////////////////////
  bcp_cache_pins dut
  (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cacheIndexOut(idxOut), .cacheStrobes(stb),
    .cacheTagBusOut(tagOut), .cacheTagBusOe(tagOe), .cacheTagBusIn(tagIn),
    .cacheDataFwdClockP(dP), .cacheDataFwdClockN(dN), .tagFwdClockP(tagP),
    .tagFwdClockN(tagN), .tagCaptureClock(capClk), .capturedFramingClock(frameClk),
    .fwdClockWakeReset(wakeIn), .supplyOkInput(supplyOk), .wakeRequest(wakeReq)
  );
  bcp_sram_model sram
  (
    .sys_clk(sys_clk), .idx(idxOut), .stb(stb), .tagOut(tagOut), .tagOe(tagOe),
    .badParity(badPar), .mute(mute), .tagIn(tagIn), .capClk(capClk)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tallyAndFinish();
    if (errCount == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic hang();
    errCount++;
    $display("Error at %0t ns: wait ran out, got %0h expected %0h", $time, 0, 1);
    tallyAndFinish();
  endtask
  // Request held until the edge that sees pready; released right after that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (n > 20)
        hang();
    end
    while (pready !== 1'b1);
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic waitStb(input logic [4:0] m, input logic v);
    int n;
    n = 0;
    prevP = tagP;
    forever
    begin
      @(posedge sys_clk);
      if ((stb & m) === (v ? m : 5'h00))
        break;
      prevP = tagP;
      n++;
      if (n > 300)
        hang();
    end
  endtask
  function automatic logic [26:0] tw(input logic [22:0] t, input logic [2:0] msv);
    return {t, msv, ^{t, msv}};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tagWrite(input logic [1:0] lag, input logic [19:0] ix,
    input logic [22:0] t, input logic [2:0] msv);
    int k, lagSeen, lowCnt;
    apb(1'b1, bcp_pkg::OFF_CTRL, 32'h14 | lag);
    apb(1'b1, bcp_pkg::OFF_INDEX, {12'h000, ix});
    apb(1'b1, bcp_pkg::OFF_WTAG, {6'h00, msv[0], msv[1], msv[2], t});
    apb(1'b1, bcp_pkg::OFF_CMD, 32'h4);
    waitStb(5'h01, 1'b0);
    chk(idxOut, ix);
    chk(tagOut, tw(t, msv));
    chk({tagOe, stb}, 6'h3A);
    lagSeen = 9;
    lowCnt = 0;
    for (k = 0; k < 10; k++)
    begin
      if (tagP === 1'b1 && prevP === 1'b0 && lagSeen == 9)
        lagSeen = k;
      lowCnt += (stb.tagWriteEnableN === 1'b0);
      prevP = tagP;
      @(posedge sys_clk);
    end
    chk(lagSeen, lag);
    chk(lowCnt, 4);
  endtask
  task automatic clocks();
    int k, hi, rises;
    hi = 0;
    rises = 0;
    prevP = tagP;
    for (k = 0; k < 16; k++)
    begin
      @(posedge sys_clk);
      hi += (tagP === 1'b1);
      rises += (tagP === 1'b1 && prevP === 1'b0);
      prevP = tagP;
      chk({dP, dN, tagN}, {{4{tagP}}, {4{~tagP}}, ~tagP});
    end
    chk(hi, 8);
    chk(rises, 4);
    // Clock enable low must freeze the divider
    clkEn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    prevP = tagP;
    repeat (6)
    begin
      @(posedge sys_clk);
      chk(tagP, prevP);
    end
    clkEn <= 1'b1;
  endtask
  // Data write held back while supply is not yet good
  task automatic dataWrite();
    int k;
    supplyOk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    apb(1'b1, bcp_pkg::OFF_CMD, 32'h2);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, bcp_pkg::OFF_STATUS, 32'h0);
    chk({stb, rdv[bcp_pkg::ST_SUPPLY_BIT], rdv[bcp_pkg::ST_PEND_BIT]}, 7'h7D);
    supplyOk <= 1'b1;
    waitStb(5'h08, 1'b0);
    chk({tagOe, stb.cacheDataReadEnableN, stb.tagReadEnableN, stb.tagWriteEnableN}, 4'h7);
    k = 0;
    repeat (10)
    begin
      k += (stb.cacheDataWriteEnableN === 1'b0);
      @(posedge sys_clk);
    end
    chk(k, 4);
  endtask
  task automatic tagRead(input logic [19:0] ix, input logic [31:0] expW,
    input logic [31:0] expSt);
    apb(1'b1, bcp_pkg::OFF_INDEX, {12'h000, ix});
    apb(1'b1, bcp_pkg::OFF_CMD, 32'h1);
    waitStb(5'h12, 1'b0);
    chk({tagOe, stb.cacheDataWriteEnableN, stb.tagWriteEnableN}, 3'h3);
    waitStb(5'h12, 1'b1);
    repeat (2) @(posedge sys_clk);
    apb(1'b0, bcp_pkg::OFF_STATUS, 32'h0);
    chk(rdv & 32'h14, expSt);
    apb(1'b0, bcp_pkg::OFF_RTAG, 32'h0);
    chk(rdv, expW);
  endtask
  // Two entries fill the buffer; the third read must wait, not vanish
  task automatic fillBuffer();
    int k;
    repeat (2)
    begin
      apb(1'b1, bcp_pkg::OFF_CMD, 32'h1);
      waitStb(5'h02, 1'b0);
      waitStb(5'h02, 1'b1);
    end
    apb(1'b1, bcp_pkg::OFF_CMD, 32'h1);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, bcp_pkg::OFF_STATUS, 32'h0);
    chk({stb.tagReadEnableN, rdv[bcp_pkg::ST_FULL_BIT], rdv[bcp_pkg::ST_PEND_BIT]}, 3'h7);
    apb(1'b0, bcp_pkg::OFF_RTAG, 32'h0);
    waitStb(5'h02, 1'b0);
    waitStb(5'h02, 1'b1);
    repeat (2) @(posedge sys_clk);
    for (k = 0; k < 3; k++)
    begin
      apb(1'b0, bcp_pkg::OFF_RTAG, 32'h0);
      chk(rdv[31], k < 2);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst = 1'b1;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    frameClk = 1'b0;
    wakeIn = 1'b0;
    supplyOk = 1'b1;
    badPar = 1'b0;
    mute = 1'b0;
    errCount = 0;
    nChecks = 0;
    repeat (2) @(posedge sys_clk);
    chk({idxOut, dP, dN, tagP, tagN}, {20'h0, 4'h0, 4'hF, 1'b0, 1'b1});
    chk({tagOe, stb}, 6'h1F);
    srst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, bcp_pkg::OFF_CTRL, 32'h0);
    chk(rdv, 32'h10);
    apb(1'b0, 12'h018, 32'h0);
    chk({lastErr, rdv[30:0]}, 32'h80000000);
    tagWrite(2'h0, 20'h00001, 23'h5A5A5A, 3'h7);
    tagWrite(2'h1, 20'hFFFFF, 23'h7FFFFF, 3'h1);
    tagWrite(2'h2, 20'h80000, 23'h000001, 3'h2);
    clocks();
    dataWrite();
    tagRead(20'h00001, {5'h10, tw(23'h5A5A5A, 3'h7)}, 32'h10);
    tagRead(20'h80000, {5'h10, tw(23'h000001, 3'h2)}, 32'h00);
    badPar <= 1'b1;
    tagRead(20'hFFFFF, {5'h10, tw(23'h7FFFFF, 3'h1) ^ 27'h1}, 32'h14);
    badPar <= 1'b0;
    apb(1'b1, bcp_pkg::OFF_STATUS, 32'h4);
    apb(1'b0, bcp_pkg::OFF_STATUS, 32'h0);
    chk(rdv[bcp_pkg::ST_PARERR_BIT], 1'b0);
    fillBuffer();
    // Silent tag memory: the read must end by the wait limit
    mute <= 1'b1;
    apb(1'b1, bcp_pkg::OFF_CMD, 32'h1);
    waitStb(5'h02, 1'b0);
    waitStb(5'h02, 1'b1);
    repeat (2) @(posedge sys_clk);
    apb(1'b0, bcp_pkg::OFF_STATUS, 32'h0);
    chk(rdv[bcp_pkg::ST_TMO_BIT], 1'b1);
    mute <= 1'b0;
    // Wake ignored until a framing edge arrives
    wakeIn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(wakeReq, 1'b0);
    frameClk <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(wakeReq, 1'b1);
    apb(1'b0, bcp_pkg::OFF_STATUS, 32'h0);
    chk(rdv[bcp_pkg::ST_WAKE_BIT], 1'b1);
    tallyAndFinish();
  end
endmodule // bcp_cache_pins_bench
